//--- trigger_halt_controller.sv
// Added by the designer: register access over Avalon-MM and the placing of the registers.
`default_nettype none
// Notes on behaviour
// - kind bit picks tag-type or force-type halt request
// - opcode qualify gates A, and B in A-or-B and A-then-B, through separate tracking circuits
// - end runs pass qualified match to halt logic, enable and kind apply
// - end run trigger stops further fifo capture
// - begin run trigger starts capture; halt raised when fifo full
// - begin run stores after trigger until eight entries held
// - end run stores until trigger, oldest dropped beyond eight
// - arm and active cleared at end trigger or begin-run fill
// - reset during enabled end run clears arm, halt enable and active only
// - active cleared by writing arm zero or while enable low
// - arming clears A, B, C flags; A and B set on mode match, C on any C match
// - non-event modes store change-of-flow, event modes store data
// - A-only sets A; A-or-B sets matching flags
// - A-then-B evaluates B only after A matched
// - event-only modes always begin-type; B match sets B, in A-then-event-B only after A
// - A-and-B sets both flags only on same-cycle double match
// - A-and-not-B sets both flags only when A and not B
// - full modes, end run, tag halts: only A decides break
// - inside range sets both when A le addr le B
// - outside range: below A sets A, above B sets B
// - mode 0x0 is A-only and 0x1 is A-or-B
module trigger_halt_controller (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // system reset seen while running (soft reset event)
  input wire logic sys_reset_i,
  // avalon-mm slave
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // comparator matches
  input wire logic match_a_i,
  input wire logic match_b_i,
  input wire logic match_c_i,
  input wire logic addr_ge_a_i,
  input wire logic addr_le_b_i,
  // opcode tracking: tagged opcode reached execution, per comparator
  input wire logic exec_a_i,
  input wire logic exec_b_i,
  // core change-of-flow indicators
  input wire logic cof_i,
  // fifo store control
  output logic fifo_store_o,
  output logic fifo_store_data_o,
  // cpu halt request
  output logic halt_tag_o,
  output logic halt_force_o
);
  logic [3:0] ctl;
  logic [5:0] setup;
  logic match_a_flag;
  logic match_b_flag;
  logic match_c_flag;
  logic capture_active_flag;
  logic triggered;
  logic seen_a;
  logic [3:0] cnt;
  logic track_a;
  logic track_b;
  logic ack;
  logic [3:0] mode;
  logic module_enable;
  logic cpu_halt_request_enable;
  logic opcode_qualify_select;
  logic kind_tag;
  logic begin_run;
  logic event_mode;
  logic hit_a;
  logic hit_b;
  logic set_a;
  logic set_b;
  logic trig;
  logic arm_write;
  logic disarm_write;
  logic end_trig;
  logic fill_done;
  logic store;

  assign module_enable = ctl[trig_pkg::CTL_ENABLE];
  assign cpu_halt_request_enable = ctl[trig_pkg::CTL_HALT_EN];
  assign kind_tag = ctl[trig_pkg::CTL_TAG];
  assign mode = setup[trig_pkg::SET_MODE_MSB:trig_pkg::SET_MODE_LSB];
  assign opcode_qualify_select = setup[trig_pkg::SET_QUALIFY];

  // event modes ignore the begin bit
  assign event_mode = (mode == trig_pkg::MODE_EVENT_B) ||
                      (mode == trig_pkg::MODE_A_THEN_EVENT_B);
  assign begin_run = setup[trig_pkg::SET_BEGIN] || event_mode;

  // qualified hits; tracking not used for event-only B
  // a tracked match only counts once its opcode reaches execution,
  // so the tracker level alone must not fire a trigger
  // limitation: while the tracker is set, an exec pulse for a
  // different opcode is taken as a qualified hit
  always_comb begin
    hit_a = opcode_qualify_select ? (track_a && exec_a_i) : match_a_i;
    hit_b = (opcode_qualify_select && !event_mode) ? (track_b && exec_b_i) :
            match_b_i;
  end

  // per-mode flag conditions
  // full modes use the raw data-side b match, never the tracked one,
  // because b there watches the data bus and carries no opcode
  // range modes read the two range compares directly
  // unlisted mode codes fall into the a-only branch
  always_comb begin
    set_a = 1'b0;
    set_b = 1'b0;
    unique case (mode)
      trig_pkg::MODE_A_OR_B: begin
        set_a = hit_a;
        set_b = hit_b;
      end
      trig_pkg::MODE_A_THEN_B, trig_pkg::MODE_A_THEN_EVENT_B: begin
        set_a = hit_a;
        set_b = hit_b && seen_a;
      end
      trig_pkg::MODE_EVENT_B: begin
        set_b = hit_b;
      end
      trig_pkg::MODE_A_AND_B: begin
        set_a = hit_a && match_b_i;
        set_b = hit_a && match_b_i;
      end
      trig_pkg::MODE_A_AND_NOT_B: begin
        set_a = hit_a && !match_b_i;
        set_b = hit_a && !match_b_i;
      end
      trig_pkg::MODE_INSIDE: begin
        set_a = addr_ge_a_i && addr_le_b_i;
        set_b = addr_ge_a_i && addr_le_b_i;
      end
      trig_pkg::MODE_OUTSIDE: begin
        set_a = !addr_ge_a_i;
        set_b = !addr_le_b_i;
      end
      default: begin
        set_a = hit_a;
      end
    endcase
  end

  // trigger condition; full-mode tagged end runs break on A alone
  // sequential and event modes fire on the b side only,
  // since the a side merely opens the window for b
  // every other mode fires on whichever flag condition is met
  always_comb begin
    unique case (mode)
      trig_pkg::MODE_A_THEN_B, trig_pkg::MODE_A_THEN_EVENT_B,
      trig_pkg::MODE_EVENT_B: trig = set_b;
      trig_pkg::MODE_A_AND_B, trig_pkg::MODE_A_AND_NOT_B:
        trig = (!begin_run && kind_tag) ? hit_a : set_a;
      default: trig = set_a || set_b;
    endcase
  end

  // bus decode: arm write is enable and arm set together
  assign arm_write = avs_write_i && !avs_waitrequest_o && (avs_address_i == trig_pkg::OFS_CONTROL)
                     && avs_writedata_i[trig_pkg::CTL_ENABLE]
                     && avs_writedata_i[trig_pkg::CTL_ARM];
  assign disarm_write = avs_write_i && !avs_waitrequest_o &&
                        (avs_address_i == trig_pkg::OFS_CONTROL) &&
                        !avs_writedata_i[trig_pkg::CTL_ARM];
  assign end_trig = capture_active_flag && !begin_run && trig;
  assign fill_done = capture_active_flag && begin_run && triggered && store &&
                     (cnt == trig_pkg::FIFO_DEPTH - trig_pkg::CNT_ONE);
  // end runs store until the trigger, begin runs from the trigger cycle on
  // event modes store one data word per qualified b match instead
  // of change-of-flow words, and those words fill the run as well
  // the trigger cycle itself stores, so a begin run counts it
  assign store = capture_active_flag &&
                 (event_mode ? set_b :
                  (cof_i && (begin_run ? (triggered || trig) : 1'b1)));

  // opcode tracking, one circuit per comparator so two queued opcodes stay apart
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      track_a <= 1'b0;
      track_b <= 1'b0;
    end else if (ce_i) begin
      track_a <= match_a_i ? 1'b1 : (exec_a_i ? 1'b0 : track_a);
      track_b <= match_b_i ? 1'b1 : (exec_b_i ? 1'b0 : track_b);
    end
  end

  // one wait cycle per access keeps the answer registered
  // the master sees waitrequest low in the second cycle of a request;
  // ack drops again right after, so a held request is not taken twice
  // back-to-back requests therefore cost two cycles each
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack <= 1'b0;
    end else if (ce_i) begin
      ack <= (avs_read_i || avs_write_i) && !ack;
    end
  end
  assign avs_waitrequest_o = !ack;

  // control register; hardware clears arm at end of run
  // hardware clears win over a software write in the same cycle,
  // so a run that ends just as software rewrites control stays ended
  // the soft reset keeps enable and kind, so the host can still
  // read what the interrupted end run captured
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctl <= 4'h0;
    end else if (ce_i) begin
      if (sys_reset_i && module_enable && !begin_run) begin
        ctl[trig_pkg::CTL_ARM] <= 1'b0;
        ctl[trig_pkg::CTL_HALT_EN] <= 1'b0;
      end else if (end_trig || fill_done) begin
        ctl[trig_pkg::CTL_ARM] <= 1'b0;
      end else if (avs_write_i && ack && avs_address_i == trig_pkg::OFS_CONTROL) begin
        ctl <= avs_writedata_i[3:0];
      end
    end
  end

  // setup register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      setup <= 6'h00;
    end else if (ce_i && avs_write_i && ack && avs_address_i == trig_pkg::OFS_SETUP) begin
      setup <= avs_writedata_i[5:0];
    end
  end

  // capture active flag
  // the arming write itself sets enable, so the old enable value
  // must not block it; otherwise the first arm after reset is lost
  // a disabled unit that is not being armed stays inactive
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      capture_active_flag <= 1'b0;
    end else if (ce_i) begin
      if ((!module_enable && !arm_write) || disarm_write) begin
        capture_active_flag <= 1'b0;
      end else if (sys_reset_i && !begin_run) begin
        capture_active_flag <= 1'b0;
      end else if (end_trig || fill_done) begin
        capture_active_flag <= 1'b0;
      end else if (arm_write) begin
        capture_active_flag <= 1'b1;
      end
    end
  end

  // match flags: arm clears, mode match sets a and b and any c match sets c while active; arm wins
  // flags freeze once the run ends, so the host reads the cause
  // of the trigger rather than later matches
  // seen_a remembers the a side for the sequential modes
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      match_a_flag <= 1'b0;
      match_b_flag <= 1'b0;
      match_c_flag <= 1'b0;
      seen_a <= 1'b0;
    end else if (ce_i) begin
      if (arm_write) begin
        match_a_flag <= 1'b0;
        match_b_flag <= 1'b0;
        match_c_flag <= 1'b0;
        seen_a <= 1'b0;
      end else if (capture_active_flag) begin
        match_a_flag <= match_a_flag || set_a;
        match_b_flag <= match_b_flag || set_b;
        match_c_flag <= match_c_flag || match_c_i;
        seen_a <= seen_a || hit_a;
      end
    end
  end

  // begin-run trigger latch and saturating word count
  // the count stops at eight; in end runs older words fall out of
  // the buffer while the count simply stays full
  // the count never decrements as words are read back
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      triggered <= 1'b0;
      cnt <= trig_pkg::CNT_ZERO;
    end else if (ce_i) begin
      if (arm_write) begin
        triggered <= 1'b0;
        cnt <= trig_pkg::CNT_ZERO;
      end else begin
        if (capture_active_flag && trig) begin
          triggered <= 1'b1;
        end
        if (store && cnt != trig_pkg::FIFO_DEPTH) begin
          cnt <= cnt + trig_pkg::CNT_ONE;
        end
      end
    end
  end

  // store strobes and halt requests, all registered
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fifo_store_o <= 1'b0;
      fifo_store_data_o <= 1'b0;
      halt_tag_o <= 1'b0;
      halt_force_o <= 1'b0;
    end else if (ce_i) begin
      fifo_store_o <= store && !event_mode;
      fifo_store_data_o <= store && event_mode;
      // halt at trigger for end runs, at fill for begin runs
      halt_tag_o <= cpu_halt_request_enable && kind_tag &&
                    (end_trig || fill_done);
      halt_force_o <= cpu_halt_request_enable && !kind_tag &&
                      (end_trig || fill_done);
    end
  end

  // read data, registered; unmapped reads zero
  // the word follows the address every cycle, so it is settled by
  // the edge at which waitrequest is seen low
  // status reads do not disturb any flag
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      avs_readdata_o <= trig_pkg::ZERO_WORD;
    end else if (ce_i) begin
      unique case (avs_address_i)
        trig_pkg::OFS_CONTROL: avs_readdata_o <= {28'h000_0000, ctl};
        trig_pkg::OFS_SETUP: avs_readdata_o <= {26'h000_0000, setup};
        trig_pkg::OFS_STATUS: avs_readdata_o <= {23'h00_0000, triggered, cnt,
          capture_active_flag, match_c_flag, match_b_flag, match_a_flag};
        default: avs_readdata_o <= trig_pkg::ZERO_WORD;
      endcase
    end
  end
endmodule : trigger_halt_controller
`default_nettype wire

//--- trig_pkg.sv
`default_nettype none
package trig_pkg;
  // trigger mode field encodings
  localparam logic [3:0] MODE_A_ONLY = 4'h0;
  localparam logic [3:0] MODE_A_OR_B = 4'h1;
  localparam logic [3:0] MODE_A_THEN_B = 4'h2;
  localparam logic [3:0] MODE_EVENT_B = 4'h3;
  localparam logic [3:0] MODE_A_THEN_EVENT_B = 4'h4;
  localparam logic [3:0] MODE_A_AND_B = 4'h5;
  localparam logic [3:0] MODE_A_AND_NOT_B = 4'h6;
  localparam logic [3:0] MODE_INSIDE = 4'h7;
  localparam logic [3:0] MODE_OUTSIDE = 4'h8;
  // fifo depth and count
  localparam logic [3:0] FIFO_DEPTH = 4'h8;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;
  // register word offsets (byte addresses)
  localparam logic [3:0] OFS_CONTROL = 4'h0;
  localparam logic [3:0] OFS_SETUP = 4'h4;
  localparam logic [3:0] OFS_STATUS = 4'h8;
  // control register bits
  localparam int CTL_ENABLE = 0;
  localparam int CTL_ARM = 1;
  localparam int CTL_HALT_EN = 2;
  localparam int CTL_TAG = 3;
  // setup register fields
  localparam int SET_MODE_LSB = 0;
  localparam int SET_MODE_MSB = 3;
  localparam int SET_BEGIN = 4;
  localparam int SET_QUALIFY = 5;
  // status register fields
  localparam int ST_A = 0;
  localparam int ST_B = 1;
  localparam int ST_C = 2;
  localparam int ST_ACTIVE = 3;
  localparam int ST_CNT_LSB = 4;
  localparam int ST_CNT_MSB = 7;
  localparam int ST_TRIG = 8;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
endpackage : trig_pkg
`default_nettype wire

//--- cpu_pipe_model.sv
`default_nettype none
module cpu_pipe_model #(
  parameter int LAT = 3
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // bench requests: tagged opcode fetched, branch taken
  input wire logic go_a_i,
  input wire logic go_b_i,
  input wire logic branch_i,
  // core indicators toward the block
  output logic exec_a_o,
  output logic exec_b_o,
  output logic cof_o
);
  logic [LAT-1:0] qa;
  logic [LAT-1:0] qb;
  // one slot chain per comparator, so two tagged opcodes travel apart
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      qa <= '0;
      qb <= '0;
    end else begin
      qa <= {qa[LAT-2:0], go_a_i};
      qb <= {qb[LAT-2:0], go_b_i};
    end
  end
  assign exec_a_o = qa[LAT-1];
  assign exec_b_o = qb[LAT-1];
  // change of flow reported one cycle after the branch
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) cof_o <= 1'b0;
    else cof_o <= branch_i;
  end
endmodule : cpu_pipe_model
`default_nettype wire

//--- trig_properties.sv
`default_nettype none
module trig_properties (
  // bus
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  // trace and halt
  input wire logic match_b_i,
  input wire logic cof_i,
  input wire logic fifo_store_o,
  input wire logic fifo_store_data_o,
  input wire logic halt_tag_o,
  input wire logic halt_force_o
);
  logic [1:0] kind;
  logic ev;
  logic acc;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  assign acc = avs_write_i && !avs_waitrequest_o;
  // kind and halt enable as last written; hardware clears only narrow it
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) kind <= 2'b00;
    else if (acc && avs_address_i == trig_pkg::OFS_CONTROL) kind <= avs_writedata_i[3:2];
  end
  // event-only mode in the setup word
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) ev <= 1'b0;
    else if (acc && avs_address_i == trig_pkg::OFS_SETUP)
      ev <= avs_writedata_i[3:0] inside {trig_pkg::MODE_EVENT_B,
        trig_pkg::MODE_A_THEN_EVENT_B};
  end
  sequence req_up;
    $rose(avs_read_i || avs_write_i);
  endsequence
  sequence one_cycle_answer;
    !avs_waitrequest_o ##1 avs_waitrequest_o;
  endsequence
  bus_answer_a: assert property (req_up |=> one_cycle_answer) else $error("bus answer off");
  answer_cause_a: assert property ($fell(avs_waitrequest_o) |-> avs_read_i || avs_write_i)
    else $error("answer without request");
  unmapped_read_a: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i > 4'h8
    |-> avs_readdata_o == trig_pkg::ZERO_WORD) else $error("unmapped read not zero");
  tag_kind_a: assert property (halt_tag_o |-> kind == 2'b11) else $error("tag halt");
  force_kind_a: assert property (halt_force_o |-> kind == 2'b01)
    else $error("force halt");
  halt_pulse_a: assert property ((halt_tag_o || halt_force_o) |=> !halt_tag_o && !halt_force_o)
    else $error("halt too long");
  cof_store_a: assert property (fifo_store_o |-> $past(cof_i) && !ev)
    else $error("cof store");
  data_store_a: assert property (fifo_store_data_o |-> $past(match_b_i) && ev)
    else $error("data store");
endmodule : trig_properties
bind trigger_halt_controller trig_properties trig_properties_inst (.clk_i, .rst_n_i,
  .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_readdata_o,
  .avs_waitrequest_o, .match_b_i, .cof_i, .fifo_store_o, .fifo_store_data_o,
  .halt_tag_o, .halt_force_o);
`default_nettype wire

//--- test_debug_trigger_break_control.sv
`default_nettype none
module test_debug_trigger_break_control;
  timeunit 1ns;
  timeprecision 1ns;
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin err_total++; \
  $display("Error %0t got %h exp %h", $time, (a), (e)); end end
  logic clk_i = 1'b0, rst_n_i = 1'b0, srst = 1'b0, rd = 1'b0, wr = 1'b0, go = 1'b0;
  logic ma = 1'b0, mb = 1'b0, mc = 1'b0, ge = 1'b0, le = 1'b0, br = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wd = 32'h0000_0000, seed = 32'h0000_176e, rdat, e, m;
  logic wt, st, sd, ea, eb, cof, ht, hf;
  int err_total = 0, cmp_count = 0, cyc = 0, nst = 0, nsd = 0, nt = 0, nf = 0;
  logic [31:0] q_e[$], q_m[$];
  // {mode, idle ranges, three hits of {a, b, ge, le}, flags}
  localparam logic [23:0] TAB [8] = '{24'h00_4081, 24'h20_4843, 24'h10_0042,
    24'h50_84c3, 24'h60_c483, 24'h90_4081, 24'h70_2133, 24'h83_3322};
  always #25 clk_i = ~clk_i;
  trigger_halt_controller trigger_halt_controller_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .ce_i(1'b1), .sys_reset_i(srst), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wd), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wt), .match_a_i(ma), .match_b_i(mb), .match_c_i(mc),
    .addr_ge_a_i(ge), .addr_le_b_i(le), .exec_a_i(ea), .exec_b_i(eb), .cof_i(cof),
    .fifo_store_o(st), .fifo_store_data_o(sd), .halt_tag_o(ht), .halt_force_o(hf));
  cpu_pipe_model cpu_pipe_model_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .go_a_i(go),
    .go_b_i(go), .branch_i(br), .exec_a_o(ea), .exec_b_o(eb), .cof_o(cof));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize
  // event counts, read checks against the oldest note, hang guard
  always @(posedge clk_i) begin
    cyc++;
    nst += int'(st);
    nsd += int'(sd);
    nt += int'(ht);
    nf += int'(hf);
    if (rd && wt === 1'b0) begin
      e = q_e.pop_front();
      m = q_m.pop_front();
      `CHK(rdat & m, e & m)
    end
    if (cyc == 6000) begin
      err_total++;
      summarize();
    end
  end
  // request held until the edge that sees waitrequest low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wr <= w;
    rd <= !w;
    adr <= a;
    wd <= d;
    do @(posedge clk_i); while (wt !== 1'b0);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus
  task automatic chk(input logic [31:0] x, k, input logic [3:0] a = trig_pkg::OFS_STATUS);
    q_e.push_back(x);
    q_m.push_back(k);
    bus(1'b0, a, seed);
  endtask : chk
  // one-cycle stimulus of {branch, a, b, ge, le}, then a random gap
  task automatic hit(input logic [4:0] v, input logic [1:0] idle);
    @(posedge clk_i);
    {br, ma, mb, ge, le} <= v;
    mc <= seed[5];
    @(posedge clk_i);
    {br, ma, mb, ge, le} <= {3'b000, idle};
    seed = lfsr(seed);
    repeat (2 + seed[1:0]) @(posedge clk_i);
  endtask : hit
  task automatic arm(input logic [31:0] s, c, input logic [1:0] idle);
    {ge, le} <= idle;
    bus(1'b1, trig_pkg::OFS_SETUP, s);
    bus(1'b1, trig_pkg::OFS_CONTROL, c);
    repeat (2) @(posedge clk_i);
  endtask : arm
  task automatic done(input string s);
    $display("test %s over, mismatches %0d", s, err_total);
  endtask : done
  initial begin
    int s0, f0, t0;
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    chk(32'h0000_0000, 32'h0000_000f, trig_pkg::OFS_CONTROL);
    chk(32'h0000_0000, 32'h0000_01ff);
    bus(1'b1, 4'hc, seed);
    chk(32'h0000_0000, 32'hffff_ffff, 4'hc);
    done("reset");
    foreach (TAB[i]) begin
      arm({28'h000_0000, TAB[i][23:20]}, 32'h0000_0003, TAB[i][17:16]);
      for (int j = 0; j < 3; j++) hit({1'b0, TAB[i][15 - 4 * j -: 4]}, TAB[i][17:16]);
      chk({30'h0000_0000, TAB[i][1:0]}, 32'h0000_00fb);
    end
    done("modes");
    for (int k = 3; k < 5; k++) begin
      f0 = nf;
      s0 = nsd;
      arm(32'(k), 32'h0000_0007, 2'b00);
      if (k == 4) hit(5'h08, 2'b00);
      repeat (10) hit(5'h04, 2'b00);
      chk(32'h0000_0082 | 32'(k - 3), 32'h0000_00fb);
      `CHK(nsd - s0, 8)
      `CHK(nf - f0, 1)
    end
    done("event");
    s0 = nst;
    f0 = nf;
    t0 = nt;
    arm(32'h0000_0000, 32'h0000_0007, 2'b00);
    repeat (10) hit(5'h10, 2'b00);
    hit(5'h08, 2'b00);
    repeat (3) hit(5'h10, 2'b00);
    chk(32'h0000_0081, 32'h0000_00fb);
    `CHK(nst - s0, 10)
    `CHK(nf - f0, 1)
    `CHK(nt - t0, 0)
    done("end run");
    s0 = nst;
    f0 = nf;
    arm(32'h0000_0011, 32'h0000_0007, 2'b00);
    repeat (2) hit(5'h10, 2'b00);
    hit(5'h04, 2'b00);
    chk(32'h0000_000a, 32'h0000_00fb);
    `CHK(nf - f0, 0)
    repeat (12) hit(5'h10, 2'b00);
    chk(32'h0000_0082, 32'h0000_00fb);
    `CHK(nst - s0, 8)
    `CHK(nf - f0, 1)
    done("begin run");
    t0 = nt;
    arm(32'h0000_0020, 32'h0000_000f, 2'b00);
    hit(5'h08, 2'b00);
    chk(32'h0000_0008, 32'h0000_0008);
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    repeat (10) @(posedge clk_i);
    chk(32'h0000_0001, 32'h0000_0009);
    `CHK(nt - t0, 1)
    done("qualify");
    arm(32'h0000_0000, 32'h0000_0003, 2'b00);
    chk(32'h0000_0008, 32'h0000_00fb);
    bus(1'b1, trig_pkg::OFS_CONTROL, 32'h0000_0001);
    chk(32'h0000_0000, 32'h0000_0008);
    arm(32'h0000_0000, 32'h0000_0007, 2'b00);
    srst <= 1'b1;
    @(posedge clk_i);
    srst <= 1'b0;
    chk(32'h0000_0001, 32'h0000_0007, trig_pkg::OFS_CONTROL);
    chk(32'h0000_0000, 32'h0000_0008);
    done("disarm");
    summarize();
  end
endmodule : test_debug_trigger_break_control
`default_nettype wire
